/* hw/hisp_pkg.sv */
package hisp_pkg;
  // Strap decode patterns on bits [2:1]
  localparam logic [1:0] STRAP_STROBE = 2'h0;
  localparam logic [1:0] STRAP_ENABLE = 2'h1;
  localparam logic [1:0] STRAP_SERIAL = 2'h2;
  localparam logic [1:0] STRAP_I2C    = 2'h3;
  // Bit positions on the host data bus
  localparam int LOW_BYTE_MSB  = 7;
  localparam int HIGH_BYTE_LSB = 8;
  // Reset values
  localparam logic [7:0]  INDEX_RESET  = 8'h00;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // Wait counter limit; the device holds wait low one cycle longer per access
  localparam int WAIT_CYCLES = 2;
  // Host timing: cycles each strobe phase lasts
  localparam int HOST_SETUP_CYCLES  = 1;
  localparam int HOST_STROBE_CYCLES = 2;
  // Number of internal registers behind the index
  localparam int REG_COUNT = 16;

  typedef enum logic [1:0] {
    HISP_MODE_STROBE = 2'b00,
    HISP_MODE_ENABLE = 2'b01,
    HISP_MODE_SPI    = 2'b10,
    HISP_MODE_I2C    = 2'b11
  } hisp_mode_t;
endpackage : hisp_pkg

/* hw/hisp_if.sv */
interface hisp_if;
  logic [2:0]  strap;        // Mode strap pins
  logic        csN;          // Chip select, active low
  logic        rdEn;         // Read strobe (low) or enable (high)
  logic        wrDir;        // Write strobe (low) or direction
  logic        cmdDataSel;   // Low command/status, high data
  logic [15:0] hostDataOut;  // Host drive value
  logic [15:0] hostDataOe;   // Host drive enables
  logic [15:0] devDataOut;   // Device drive value
  logic [15:0] devDataOe;    // Device drive enables
  logic        waitN;        // Device wait, low stretches cycle
  logic        intN;         // Device interrupt, active low
  wire  [15:0] busLevel;     // Resolved bus, pulled high when idle

  genvar b;
  for (b = 0; b < 16; b++)
  begin : g_bus
    assign busLevel[b] = devDataOe[b] ? devDataOut[b] :
                         hostDataOe[b] ? hostDataOut[b] : 1'b1;
  end

  modport device (input strap, csN, rdEn, wrDir, cmdDataSel, busLevel,
                  output devDataOut, devDataOe, waitN, intN);
  modport host (output strap, csN, rdEn, wrDir, cmdDataSel, hostDataOut,
                hostDataOe, input busLevel, waitN, intN);
endinterface : hisp_if

/* hw/hisp_device.sv */
// Summary of operation
// [RL1] Strap pins select one of four protocols
// [RL2] Lowest strap becomes interrupt input in parallel
// [RL3] Upper byte is GPIO A unless 16-bit
// [RL4] Serial modes give lower byte to serial pins
// [RL5] Chip select low enables parallel access
// [RL6] Strobe mode: low read or write pulses
// [RL7] Enable mode: direction plus high enable
// [RL8] Select low status/command, high data
// [RL9] Wait low stretches host cycle until ready
// [RL10] Active-low interrupt output shows status
// [RL11] Serial modes: control pins become inputs
// [RL12] Command writes index, data accesses register
module hisp_device #(
  parameter int REGS = hisp_pkg::REG_COUNT
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  hisp_if.device           bus,
  input  wire logic        wide16,
  input  wire logic [15:0] statusIn,
  input  wire logic [7:0]  gpioAOut,
  input  wire logic [7:0]  gpioAOe,
  output logic      [1:0]  modeSel,
  output logic             extIrq,
  output logic      [7:0]  gpioAIn,
  output logic      [7:0]  serialPins,
  output logic      [3:0]  gpinGroupB,
  output logic      [7:0]  regIndex,
  output logic             regWrPulse,
  output logic      [15:0] regWrData
);
  logic [1:0]  modeQ;
  logic        strapDoneQ;
  logic [7:0]  indexQ;
  logic [15:0] regsQ [REGS];
  logic [15:0] rdDataQ;
  logic        activeQ;
  logic        isWriteQ;
  logic        isDataQ;
  logic [1:0]  waitCntQ;
  logic        waitNQ;
  logic        intNQ;
  logic        extIrqQ;
  logic [7:0]  gpioAInQ;
  logic [7:0]  serialQ;
  logic [3:0]  gpinQ;
  logic        wrPulseQ;
  logic [15:0] wrDataQ;
  logic [15:0] oeQ;
  logic [15:0] devOutQ;
  // Index width follows the size of the register file
  localparam int IDXW = $clog2(REGS);

  // Parallel modes; wide data only when parallel and configured
  wire isParallel = ~modeQ[1];
  wire isWide     = isParallel & wide16;
  wire isStrobe   = modeQ == hisp_pkg::HISP_MODE_STROBE;
  // Access request decode for each bus flavour
  wire strobeRd = ~bus.rdEn & bus.wrDir;                    // [RL6]
  wire strobeWr = ~bus.wrDir & bus.rdEn;                    // [RL6]
  wire enRd     = bus.rdEn & bus.wrDir;                     // [RL7]
  wire enWr     = bus.rdEn & ~bus.wrDir;                    // [RL7]
  wire reqRd    = isStrobe ? strobeRd : enRd;
  wire reqWr    = isStrobe ? strobeWr : enWr;
  wire selected = isParallel & ~bus.csN;                    // [RL5]
  wire reqAny   = selected & (reqRd | reqWr);
  wire [15:0] busData = isWide ? bus.busLevel
                               : {8'h00, bus.busLevel[7:0]};
  // Out-of-range index folds to zero rather than wrapping
  wire [7:0]  idxSafe = indexQ < 8'(REGS) ? indexQ : 8'h00;
  // Status read on select low, register read on select high
  wire [15:0] rdSel = bus.cmdDataSel ? regsQ[idxSafe[IDXW-1:0]]
                                     : statusIn;            // [RL8]
  wire waitDone = waitCntQ == 2'(hisp_pkg::WAIT_CYCLES);

  // Strap is caught once after reset release, not under reset
  // Later strap changes are ignored; pattern 101 decodes as serial
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      modeQ      <= 2'h0;
      strapDoneQ <= 1'b0;
    end
    else if (!strapDoneQ)
    begin
      modeQ      <= bus.strap[2:1];                         // [RL1]
      strapDoneQ <= 1'b1;
    end
  end

  // Access tracker; wait held low for a fixed count per access
  // Host must drop its strobe before the next access is taken
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      activeQ  <= 1'b0;
      isWriteQ <= 1'b0;
      isDataQ  <= 1'b0;
      waitCntQ <= 2'h0;
      waitNQ   <= 1'b1;
      rdDataQ  <= hisp_pkg::STATUS_RESET;
    end
    else if (!activeQ && reqAny && strapDoneQ)
    begin
      activeQ  <= 1'b1;
      isWriteQ <= reqWr;
      isDataQ  <= bus.cmdDataSel;
      waitCntQ <= 2'h0;
      waitNQ   <= 1'b0;                                     // [RL9]
    end
    else if (activeQ && !waitDone)
    begin
      waitCntQ <= waitCntQ + 2'h1;
      rdDataQ  <= rdSel;
    end
    else if (activeQ && waitNQ == 1'b0)
      waitNQ <= 1'b1;                                       // [RL9]
    else if (activeQ && !reqAny)
      activeQ <= 1'b0;
  end

  // Write captured when ready is given, then host may end strobe
  // Fires for one cycle only: wait rises on the following edge
  wire wrFire = activeQ & waitDone & ~waitNQ & isWriteQ;

  // Indirect register file behind the index
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      indexQ   <= hisp_pkg::INDEX_RESET;
      wrPulseQ <= 1'b0;
      wrDataQ  <= 16'h0000;
      for (int i = 0; i < REGS; i++)
        regsQ[i] <= 16'h0000;
    end
    else
    begin
      // Index and data share the write window; select picks which
      wrPulseQ <= wrFire & isDataQ;
      if (wrFire && !isDataQ)
        indexQ <= busData[7:0];                             // [RL12]
      if (wrFire && isDataQ)
      begin
        regsQ[idxSafe[IDXW-1:0]] <= busData;                // [RL12]
        wrDataQ                  <= busData;
      end
    end
  end

  // Read drive: low byte always, high byte only in wide mode
  wire rdDrive = activeQ & ~isWriteQ & selected;
  wire [15:0] oeD = {{8{rdDrive & isWide}} | (isWide ? 8'h00 : gpioAOe),
                     {8{rdDrive}}};                         // [RL3]
  // Drive ends one edge after chip select rises; the host
  // keeps off the bus until its next setup cycle

  // Output word: GPIO A in the upper byte unless wide
  wire [15:0] devOutD = {isWide ? rdDataQ[15:8] : gpioAOut,
                         rdDataQ[7:0]};                     // [RL3]

  // Pin sampling and output registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      intNQ    <= 1'b1;
      extIrqQ  <= 1'b0;
      gpioAInQ <= 8'h00;
      serialQ  <= 8'h00;
      gpinQ    <= 4'h0;
      oeQ      <= 16'h0000;
      devOutQ  <= 16'h0000;
    end
    else
    begin
      // Interrupt is a level: low while any status bit is set
      intNQ    <= ~|statusIn;                               // [RL10]
      extIrqQ  <= isParallel & bus.strap[0];                // [RL2]
      // GPIO A input reads zero in wide mode, where the byte is data
      gpioAInQ <= isWide ? 8'h00 : bus.busLevel[15:8];      // [RL3]
      // Serial pins and group B read as zero in parallel modes
      serialQ  <= isParallel ? 8'h00 : bus.busLevel[7:0];   // [RL4]
      gpinQ    <= isParallel ? 4'h0
                  : {bus.cmdDataSel, bus.wrDir, bus.rdEn,
                     bus.csN};                              // [RL11]
      oeQ      <= isParallel ? oeD : {oeD[15:8], 8'h00};    // [RL4]
      // Data pins registered so they change only with the enables
      devOutQ  <= devOutD;                                  // [RL3]
    end
  end

  // Every bus pin and status output comes straight from a flop
  assign bus.devDataOut = devOutQ;
  assign bus.devDataOe  = oeQ;
  assign bus.waitN      = waitNQ;
  assign bus.intN       = intNQ;
  assign modeSel        = modeQ;
  assign extIrq         = extIrqQ;
  assign gpioAIn        = gpioAInQ;
  assign serialPins     = serialQ;
  assign gpinGroupB     = gpinQ;
  assign regIndex       = indexQ;
  assign regWrPulse     = wrPulseQ;
  assign regWrData      = wrDataQ;
endmodule // hisp_device

/* hw/hisp_host.sv */
// Host end: one parallel access per request, stretched by wait
module hisp_host (
  input  wire logic        clk,
  input  wire logic        nrst,
  hisp_if.host             bus,
  input  wire logic [2:0]  strapSel,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic        reqData,
  input  wire logic [15:0] reqWdata,
  output logic             reqReady,
  output logic             rspValid,
  output logic      [15:0] rspData,
  output logic             intPending
);
  typedef enum logic [1:0] {
    HISP_IDLE   = 2'b00,
    HISP_SETUP  = 2'b01,
    HISP_STROBE = 2'b10,
    HISP_HOLD   = 2'b11
  } hisp_hstate_t;

  hisp_hstate_t stateQ;
  logic [1:0]   cntQ;
  logic         wrQ;
  logic         dataQ;
  logic [15:0]  wdQ;
  logic         rspValidQ;
  logic [15:0]  rspDataQ;
  logic         intQ;

  wire strobeMode = strapSel[2:1] == hisp_pkg::STRAP_STROBE;
  wire inCycle    = stateQ == HISP_STROBE;
  wire inFrame    = stateQ != HISP_IDLE;
  wire setupDone  = cntQ == 2'(hisp_pkg::HOST_SETUP_CYCLES - 1);
  wire strobeMin  = cntQ >= 2'(hisp_pkg::HOST_STROBE_CYCLES - 1);

  // Sequencer; strobe held while wait is low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stateQ    <= HISP_IDLE;
      cntQ      <= 2'h0;
      wrQ       <= 1'b0;
      dataQ     <= 1'b0;
      wdQ       <= 16'h0000;
      rspValidQ <= 1'b0;
      rspDataQ  <= 16'h0000;
      intQ      <= 1'b0;
    end
    else
    begin
      rspValidQ <= 1'b0;
      intQ      <= ~bus.intN;                               // [RL10]
      case (stateQ)
        HISP_IDLE:
          if (reqValid)
          begin
            wrQ    <= reqWrite;
            dataQ  <= reqData;                              // [RL8]
            wdQ    <= reqWdata;
            cntQ   <= 2'h0;
            stateQ <= HISP_SETUP;
          end
        HISP_SETUP:
          if (setupDone)
          begin
            cntQ   <= 2'h0;
            stateQ <= HISP_STROBE;
          end
          else
            cntQ <= cntQ + 2'h1;
        HISP_STROBE:
          if (strobeMin && bus.waitN)                       // [RL9]
          begin
            rspDataQ  <= bus.busLevel;
            rspValidQ <= ~wrQ;
            stateQ    <= HISP_HOLD;
          end
          else if (!strobeMin)
            cntQ <= cntQ + 2'h1;
        HISP_HOLD:
          stateQ <= HISP_IDLE;
        default:
          stateQ <= HISP_IDLE;
      endcase
    end
  end

  // Strobe or enable pin levels for the selected bus type
  wire rdLvl = strobeMode ? ~(inCycle & ~wrQ) : inCycle;    // [RL6] [RL7]
  wire wrLvl = strobeMode ? ~(inCycle & wrQ) : ~wrQ;        // [RL6] [RL7]

  assign bus.strap       = strapSel;
  assign bus.csN         = ~inFrame;                        // [RL5]
  assign bus.rdEn        = rdLvl;
  assign bus.wrDir       = wrLvl;
  assign bus.cmdDataSel  = dataQ;
  assign bus.hostDataOut = wdQ;
  assign bus.hostDataOe  = {16{inFrame & wrQ}};
  assign reqReady        = stateQ == HISP_IDLE;
  assign rspValid        = rspValidQ;
  assign rspData         = rspDataQ;
  assign intPending      = intQ;
endmodule // hisp_host

/* bench/hisp_checker.sv */
// Watches the shared pins between host and device ends
module hisp_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [2:0]  strap,
  input wire logic        csN,
  input wire logic        rdEn,
  input wire logic        wrDir,
  input wire logic [15:0] devDataOe,
  input wire logic        waitN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Stretch is a fixed count; a gap follows before the next one
  sequence stretchSeq;
    !waitN [*3] ##1 waitN;
  endsequence
  sequence recoverSeq;
    waitN [*3];
  endsequence

  // Wait timing, and what may start a stretch
  a_stretch_len: assert property ($fell(waitN) |-> stretchSeq)
    else $error("wait stretch has wrong length");
  a_wait_recover: assert property ($rose(waitN) |-> recoverSeq)
    else $error("wait fell again too soon");
  a_stretch_cs: assert property ($fell(waitN) |-> $past(!csN))
    else $error("wait fell without chip select");
  a_strobe_cause: assert property ($fell(waitN) &&
    strap[2:1] == hisp_pkg::STRAP_STROBE |-> $past(!rdEn || !wrDir))
    else $error("wait fell without a strobe");
  a_enable_cause: assert property ($fell(waitN) &&
    strap[2:1] == hisp_pkg::STRAP_ENABLE |-> $past(rdEn))
    else $error("wait fell without enable");
  // Serial modes never take a parallel cycle
  a_serial_nowait: assert property (strap[2] |-> waitN)
    else $error("wait low in serial mode");
  a_serial_quiet: assert property (strap[2] |->
    devDataOe[7:0] == 8'h00)
    else $error("low byte driven in serial mode");
  // Read data only while a selected read is under way
  a_read_drive: assert property (devDataOe[0] |->
    $past(!csN && wrDir))
    else $error("bus driven outside a read");
endmodule // hisp_checker

/* bench/hisp_bench.sv */
module hisp_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  strapSel = 3'h0;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic        reqData = 1'b0;
  logic [15:0] reqWdata = 16'h0000;
  logic        wide16 = 1'b1;
  logic [15:0] statusIn = 16'h0000;
  logic [7:0]  gpioAOut = 8'h00;
  logic [7:0]  gpioAOe = 8'h00;
  logic        reqReady, rspValid, intPending, extIrq, regWrPulse;
  logic [15:0] rspData, regWrData, rd;
  logic [15:0] lastWr = 16'h0000;
  logic [7:0]  gpioAIn, serialPins, regIndex;
  logic [3:0]  gpinGroupB;
  logic [1:0]  modeSel;
  int          fails = 0;
  int          checks = 0;
  int          rdPulses = 0;

  always #4 clk = ~clk;

  hisp_if hb ();
  hisp_device hisp_device_i (.clk(clk), .nrst(nrst), .bus(hb),
    .wide16(wide16), .statusIn(statusIn), .gpioAOut(gpioAOut),
    .gpioAOe(gpioAOe), .modeSel(modeSel), .extIrq(extIrq),
    .gpioAIn(gpioAIn), .serialPins(serialPins), .gpinGroupB(gpinGroupB),
    .regIndex(regIndex), .regWrPulse(regWrPulse), .regWrData(regWrData));
  hisp_host hisp_host_i (.clk(clk), .nrst(nrst), .bus(hb),
    .strapSel(strapSel), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqData(reqData), .reqWdata(reqWdata), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .intPending(intPending));
  hisp_checker hisp_checker_i (.clk(clk), .nrst(nrst), .strap(hb.strap),
    .csN(hb.csN), .rdEn(hb.rdEn), .wrDir(hb.wrDir),
    .devDataOe(hb.devDataOe), .waitN(hb.waitN));

  // Keep the last word handed to the register file, count read answers
  always @(posedge clk)
  begin
    if (regWrPulse === 1'b1)
      lastWr <= regWrData;
    if (rspValid === 1'b1)
      rdPulses <= rdPulses + 1;
  end

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Strap is only sampled after reset, so every mode change resets
  task automatic start(input logic [2:0] s, input logic w);
    @(negedge clk);
    nrst = 1'b0;
    strapSel = s;
    wide16 = w;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  // One host access; the host returns to idle when done
  task automatic acc(input logic w, input logic d, input logic [15:0] wd);
    int n;
    reqValid = 1'b1;
    reqWrite = w;
    reqData = d;
    reqWdata = wd;
    for (n = 0; reqReady !== 1'b1 && n < 50; n++)
      @(negedge clk);
    @(negedge clk);
    reqValid = 1'b0;
    @(negedge clk);
    for (n = 0; reqReady !== 1'b1 && n < 50; n++)
      @(negedge clk);
    if (n == 50)
      chk("access done", 16'h0000, 16'h0001);
    rd = rspData;
  endtask

  task automatic t_strobe;
    start(3'b001, 1'b1);
    chk("mode", 16'(modeSel), 16'h0000);
    chk("ext irq", 16'(extIrq), 16'h0001);
    acc(1'b1, 1'b0, 16'h0005);
    chk("index", 16'(regIndex), 16'h0005);
    acc(1'b1, 1'b1, 16'hA5C3);
    chk("wr data", lastWr, 16'hA5C3);
    acc(1'b0, 1'b1, 16'h0000);
    chk("rd data", rd, 16'hA5C3);
    chk("rd pulses", 16'(rdPulses), 16'h0001);
    statusIn = 16'h0004;
    repeat (4) @(negedge clk);
    chk("int pin", 16'(hb.intN), 16'h0000);
    chk("int seen", 16'(intPending), 16'h0001);
    acc(1'b0, 1'b0, 16'h0000);
    chk("status", rd, 16'h0004);
    statusIn = 16'h0000;
    repeat (4) @(negedge clk);
    chk("int off", 16'(hb.intN), 16'h0001);
    $display("strobe test done");
  endtask

  task automatic t_enable;
    start(3'b010, 1'b0);
    gpioAOut = 8'h5A;
    gpioAOe = 8'hFF;
    chk("mode", 16'(modeSel), 16'h0001);
    chk("ext irq", 16'(extIrq), 16'h0000);
    repeat (3) @(negedge clk);
    chk("gpio a", 16'(gpioAIn), 16'h005A);
    acc(1'b1, 1'b0, 16'h0007);
    acc(1'b1, 1'b1, 16'h1234);
    chk("narrow wr", lastWr, 16'h0034);
    acc(1'b0, 1'b1, 16'h0000);
    chk("narrow rd", 16'(rd[7:0]), 16'h0034);
    chk("gpio a rd", 16'(rd[15:8]), 16'h005A);
    // Index past the end folds onto register zero
    acc(1'b1, 1'b0, 16'h0014);
    acc(1'b1, 1'b1, 16'h00EE);
    acc(1'b1, 1'b0, 16'h0000);
    acc(1'b0, 1'b1, 16'h0000);
    chk("fold rd", 16'(rd[7:0]), 16'h00EE);
    chk("rd pulses", 16'(rdPulses), 16'h0004);
    $display("enable test done");
  endtask

  task automatic t_serial(input logic [2:0] s, input logic [1:0] m);
    start(s, 1'b1);
    chk("mode", 16'(modeSel), 16'(m));
    chk("serial pins", 16'(serialPins), 16'h00FF);
    chk("group b", 16'(gpinGroupB), 16'({hb.cmdDataSel, hb.wrDir,
      hb.rdEn, hb.csN}));
    chk("cs bit", 16'(gpinGroupB[0]), 16'h0001);
    $display("serial test done");
  endtask

  initial
  begin
    #(5000 * 8);
    fails++;
    finish_test();
  end

  initial
  begin
    t_strobe();
    t_enable();
    t_serial(3'b100, 2'h2);
    t_serial(3'b110, 2'h3);
    finish_test();
  end
endmodule // hisp_bench
